//--- verilog/msmm_top.sv
`timescale 1ns/10ps
module msmm_top #(
   parameter bit LARGE_EEPROM = 1'b0
) (
   // clock and reset
   input  wire logic                 clk,
   input  wire logic                 rst,
   // wishbone register slave
   input  wire logic                 wb_cyc_i,
   input  wire logic                 wb_stb_i,
   input  wire logic                 wb_we_i,
   input  wire logic [15:0]          wb_adr_i,
   input  wire logic [3:0]           wb_sel_i,
   input  wire logic [31:0]          wb_dat_i,
   output      logic [31:0]          wb_dat_o,
   output      logic                 wb_ack_o,
   // mode strapping pins
   input  wire logic                 modePinAIn,
   output      logic                 modePinAOut,
   output      logic                 modePinAOe,
   input  wire logic                 modePinB,
   // cpu side status
   input  wire logic                 instrFirstCycle,
   input  wire logic                 cpuEPhase,
   // cpu bus address decode
   input  wire logic                 cpuReq,
   input  wire logic                 cpuWe,
   input  wire logic [15:0]          cpuAddr,
   input  wire logic [3:0]           regPage,
   input  wire logic [3:0]           ramPage,
   input  wire logic                 romEnableCfg,
   input  wire logic [3:0]           eepromBaseSelect,
   output      logic                 selRegs,
   output      logic                 selRam,
   output      logic                 selRom,
   output      logic                 selBootRom,
   output      logic                 selEeprom,
   output      logic                 selExternal,
   // external bus and pins
   output      logic                 readVisible,
   output      logic                 eClkPin,
   // mode state
   output msmm_pkg::msmm_mode_t      opMode,
   output      logic [15:0]          resetVector
);
   import msmm_pkg::*;

   // ----------------------------------------------------------------------
   // declarations
   // ----------------------------------------------------------------------
   logic       modeASync1;
   logic       modeASync2;
   logic       modeBSync1;
   logic       modeBSync2;
   logic       pinsLatched;
   logic       latchNow;
   logic       bootRomEnable;
   logic       specialMode;
   logic       modeSelA;
   logic       readVisOrEOff;
   logic [3:0] prioritySelect;
   logic       mdaWritten;
   logic       irvWritten;
   logic       wbReq;
   logic       wbRegHit;
   logic       regWrite;
   logic [7:0] regValue;
   logic       hitRegs;
   logic       hitRam;
   logic       hitRom;
   logic       hitBoot;
   logic       hitEeprom;
   logic       rom_enable_cfg;

   // address window match, used for every resource of the map
   function automatic logic msmm_hit(
      input logic [15:0] addr,
      input logic [15:0] base,
      input logic [15:0] mask
   );
      msmm_hit = ((addr ^ base) & ~mask) == 16'h0000;
   endfunction : msmm_hit

   // ----------------------------------------------------------------------
   // mode pin synchronisers, running through reset
   // ----------------------------------------------------------------------
   // no reset here so the pins are already settled when reset lifts
   always_ff @(posedge clk)
   begin
      modeASync1 <= modePinAIn;
      modeASync2 <= modeASync1;
      modeBSync1 <= modePinB;
      modeBSync2 <= modeBSync1;
   end

   // ----------------------------------------------------------------------
   // strap capture at reset release
   // ----------------------------------------------------------------------
   // one-shot marker: the first edge after release captures the pins
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         pinsLatched <= 1'h0;
      else
         pinsLatched <= 1'h1;
   end

   assign latchNow = ~pinsLatched;

   // vector location follows the captured level of pin B
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         resetVector <= MSMM_VEC_NORMAL;
      else if (latchNow)
         resetVector <= modeBSync2 ? MSMM_VEC_NORMAL
                                   : MSMM_VEC_SPEC;
   end

   // ----------------------------------------------------------------------
   // wishbone slave
   // ----------------------------------------------------------------------
   assign wbReq    = wb_cyc_i & wb_stb_i;
   assign wbRegHit = wb_adr_i == MSMM_MMC_ADDR;
   // writes land on the edge where the master samples ack
   assign regWrite = wbReq & wb_ack_o & wb_we_i & wb_sel_i[0]
                   & wbRegHit & pinsLatched;

   // one wait state, then ack for a single cycle
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         wb_ack_o <= 1'h0;
      else
         wb_ack_o <= wbReq & ~wb_ack_o;
   end

   // read data, zero for unmapped addresses and unused lanes
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         wb_dat_o <= MSMM_UNMAPPED;
      else if (wbReq & ~wb_ack_o)
         wb_dat_o <= wbRegHit ? {24'h000000, regValue}
                              : MSMM_UNMAPPED;
   end

   // ----------------------------------------------------------------------
   // mode and misc control register fields
   // ----------------------------------------------------------------------
   // readback image of the control register
   always_comb
   begin
      regValue                               = 8'h00;
      regValue[MSMM_BOOT_BIT]                = bootRomEnable;
      regValue[MSMM_SPEC_BIT]                = specialMode;
      regValue[MSMM_MDA_BIT]                 = modeSelA;
      regValue[MSMM_IRV_BIT]                 = readVisOrEOff;
      regValue[MSMM_PSEL_MSB:MSMM_PSEL_LSB]  = prioritySelect;
   end

   // special mode flag: loaded from pin B, software may only clear it
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         specialMode <= MSMM_FLAG_RST;
      else if (latchNow)
         specialMode <= ~modeBSync2;
      else if (regWrite & specialMode)
         specialMode <= wb_dat_i[MSMM_SPEC_BIT];
   end

   // mode select A: free in special modes, once in normal modes
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         modeSelA <= MSMM_FLAG_RST;
      else if (latchNow)
         modeSelA <= modeASync2;
      else if (regWrite & (specialMode | ~mdaWritten))
         modeSelA <= wb_dat_i[MSMM_MDA_BIT];
   end

   // a write made in a normal mode uses up the single chance
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         mdaWritten <= 1'h0;
      else if (regWrite & ~specialMode)
         mdaWritten <= 1'h1;
   end

   // boot ROM enable: set only in bootstrap, writable in special modes
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         bootRomEnable <= MSMM_FLAG_RST;
      else if (latchNow)
         bootRomEnable <= ~modeBSync2 & ~modeASync2;
      else if (regWrite & specialMode)
         bootRomEnable <= wb_dat_i[MSMM_BOOT_BIT];
   end

   // visibility / E-off bit: set only in test mode, one write ever
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         readVisOrEOff <= MSMM_FLAG_RST;
      else if (latchNow)
         readVisOrEOff <= ~modeBSync2 & modeASync2;
      else if (regWrite & ~irvWritten)
         readVisOrEOff <= wb_dat_i[MSMM_IRV_BIT];
   end

   // marks the visibility bit as used in every mode
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         irvWritten <= 1'h0;
      else if (regWrite)
         irvWritten <= 1'h1;
   end

   // priority select field, writable in every mode and only read back here
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         prioritySelect <= MSMM_PSEL_RST;
      else if (regWrite)
         prioritySelect <= wb_dat_i[MSMM_PSEL_MSB:MSMM_PSEL_LSB];
   end

   // ----------------------------------------------------------------------
   // operating mode from the live flags
   // ----------------------------------------------------------------------
   always_comb
   begin
      unique case ({specialMode, modeSelA})
         2'b00:   opMode = MSMM_SINGLE;
         2'b01:   opMode = MSMM_EXPANDED;
         2'b10:   opMode = MSMM_BOOTSTRAP;
         2'b11:   opMode = MSMM_TEST;
      endcase
   end

   // ----------------------------------------------------------------------
   // address decoder
   // ----------------------------------------------------------------------
   // expanded modes need the config bit, others always map the ROM
   assign rom_enable_cfg = modeSelA ? romEnableCfg : 1'h1;

   // raw window matches for each resource
   always_comb
   begin
      hitRegs = msmm_hit(cpuAddr, {regPage, MSMM_PAGE_OFS}, MSMM_REG_MASK);
      hitRam  = msmm_hit(cpuAddr, {ramPage, MSMM_PAGE_OFS}, MSMM_RAM_MASK);
      hitRom  = rom_enable_cfg & msmm_hit(cpuAddr, MSMM_ROM_BASE, MSMM_ROM_MASK);
      // boot ROM only while special and enabled
      hitBoot = specialMode & bootRomEnable
              & msmm_hit(cpuAddr, MSMM_BOOT_BASE, MSMM_BOOT_MASK);
      if (LARGE_EEPROM)
         hitEeprom = msmm_hit(cpuAddr, {eepromBaseSelect, MSMM_EEL_OFS},
                              MSMM_EEL_MASK);
      else
         hitEeprom = msmm_hit(cpuAddr, MSMM_EES_BASE,
                              MSMM_EES_MASK);
   end

   // one-hot selects by fixed priority, same cycle as the address
   always_comb
   begin
      selRegs     = 1'h0;
      selRam      = 1'h0;
      selRom      = 1'h0;
      selBootRom  = 1'h0;
      selEeprom   = 1'h0;
      selExternal = 1'h0;
      if (cpuReq)
      begin
         if (hitRegs)
            selRegs = 1'h1;
         else if (hitRam)
            selRam = 1'h1;
         else if (hitBoot)
            selBootRom = 1'h1;
         else if (hitEeprom)
            selEeprom = 1'h1;
         else if (hitRom)
            selRom = 1'h1;
         else
            selExternal = 1'h1;
      end
   end

   // ----------------------------------------------------------------------
   // external bus visibility and E clock
   // ----------------------------------------------------------------------
   // internal read data shown outside in expanded and test modes
   assign readVisible = cpuReq & ~cpuWe & ~selExternal
                      & modeSelA & readVisOrEOff;

   // E pin: free in expanded modes, gated by the bit otherwise
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         eClkPin <= 1'h0;
      else if (modeSelA)
         eClkPin <= cpuEPhase;
      else
         eClkPin <= cpuEPhase & ~readVisOrEOff;
   end

   // ----------------------------------------------------------------------
   // load instruction strobe on pin A
   // ----------------------------------------------------------------------
   // open drain: only ever pulls low, never during reset or capture
   assign modePinAOut = 1'h0;

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         modePinAOe <= 1'h0;
      else
         modePinAOe <= pinsLatched & instrFirstCycle;
   end

endmodule : msmm_top

//--- pkg/msmm_pkg.sv
package msmm_pkg;

   // ----------------------------------------------------------------------
   // register location and field layout
   // ----------------------------------------------------------------------
   localparam logic [15:0] MSMM_MMC_ADDR   = 16'h103c;
   localparam int          MSMM_BOOT_BIT   = 7;
   localparam int          MSMM_SPEC_BIT   = 6;
   localparam int          MSMM_MDA_BIT    = 5;
   localparam int          MSMM_IRV_BIT    = 4;
   localparam int          MSMM_PSEL_LSB   = 0;
   localparam int          MSMM_PSEL_MSB   = 3;

   // ----------------------------------------------------------------------
   // values after reset
   // ----------------------------------------------------------------------
   localparam logic [3:0]  MSMM_PSEL_RST   = 4'h6;
   localparam logic        MSMM_FLAG_RST   = 1'h0;
   localparam logic [31:0] MSMM_UNMAPPED   = 32'h0000_0000;

   // ----------------------------------------------------------------------
   // memory map: bases and masks of the low, don't-care address bits
   // ----------------------------------------------------------------------
   localparam logic [15:0] MSMM_REG_MASK   = 16'h003f;
   localparam logic [15:0] MSMM_RAM_MASK   = 16'h01ff;
   localparam logic [15:0] MSMM_ROM_BASE   = 16'he000;
   localparam logic [15:0] MSMM_ROM_MASK   = 16'h1fff;
   localparam logic [15:0] MSMM_BOOT_BASE  = 16'hbf00;
   localparam logic [15:0] MSMM_BOOT_MASK  = 16'h00ff;
   localparam logic [15:0] MSMM_EES_BASE   = 16'hb600;
   localparam logic [15:0] MSMM_EES_MASK   = 16'h01ff;
   localparam logic [11:0] MSMM_EEL_OFS    = 12'h800;
   localparam logic [15:0] MSMM_EEL_MASK   = 16'h07ff;
   localparam logic [11:0] MSMM_PAGE_OFS   = 12'h000;

   // ----------------------------------------------------------------------
   // reset vector locations
   // ----------------------------------------------------------------------
   localparam logic [15:0] MSMM_VEC_NORMAL = 16'hfffa;
   localparam logic [15:0] MSMM_VEC_SPEC   = 16'hbffa;

   // ----------------------------------------------------------------------
   // operating modes
   // ----------------------------------------------------------------------
   typedef enum logic [3:0] {
      MSMM_SINGLE    = 4'b0001,
      MSMM_EXPANDED  = 4'b0010,
      MSMM_BOOTSTRAP = 4'b0100,
      MSMM_TEST      = 4'b1000
   } msmm_mode_t;

endpackage : msmm_pkg

//--- sim/msmm_top_asserts.sv
`timescale 1ns/10ps
// ----------------------------------------------------------------------
// port checker for the mode latch and address decoder
// ----------------------------------------------------------------------
module msmm_top_asserts (
   // clock and reset
   input wire logic                 clk,
   input wire logic                 rst,
   // register bus
   input wire logic                 wb_cyc_i,
   input wire logic                 wb_stb_i,
   input wire logic                 wb_we_i,
   input wire logic                 wb_ack_o,
   // pins and cpu status
   input wire logic                 instrFirstCycle,
   input wire logic                 cpuEPhase,
   input wire logic                 modePinAOe,
   input wire logic                 eClkPin,
   // decoder
   input wire logic                 cpuReq,
   input wire logic                 cpuWe,
   input wire logic [15:0]          cpuAddr,
   input wire logic [3:0]           regPage,
   input wire logic [3:0]           ramPage,
   input wire logic                 selRegs,
   input wire logic                 selRam,
   input wire logic                 selRom,
   input wire logic                 selBootRom,
   input wire logic                 selEeprom,
   input wire logic                 selExternal,
   input wire logic                 readVisible,
   // mode state
   input wire msmm_pkg::msmm_mode_t opMode,
   input wire logic [15:0]          resetVector
);
   import msmm_pkg::*;
   logic [5:0] sels;
   logic       regHit;
   logic       ramHit;
   logic       special;
   // hits worked out from the map layout
   assign sels    = {selRegs, selRam, selRom, selBootRom, selEeprom,
                     selExternal};
   assign regHit  = cpuAddr[15:12] == regPage && cpuAddr[11:6] == 6'h00;
   assign ramHit  = cpuAddr[15:12] == ramPage && cpuAddr[11:9] == 3'h0;
   assign special = opMode == MSMM_BOOTSTRAP || opMode == MSMM_TEST;

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   // bus answer timing
   chk_ack_take : assert property (
      (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o)
      else $error("no ack one cycle after request");
   chk_ack_pulse : assert property (
      wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   // decoder priority and gating
   chk_reg_first : assert property (
      (cpuReq && regHit) |-> sels == 6'h20)
      else $error("register block lost its address");
   chk_ram_over : assert property (
      (cpuReq && ramHit && !regHit) |-> sels == 6'h10)
      else $error("ram lost to a lower resource");
   chk_rom_on : assert property (
      (cpuReq && cpuAddr[15:13] == 3'h7 && !regHit && !ramHit &&
       (opMode == MSMM_SINGLE || opMode == MSMM_BOOTSTRAP)) |-> selRom)
      else $error("program rom off in single or bootstrap");
   chk_boot_gate : assert property (
      selBootRom |-> (special && cpuAddr[15:8] == 8'hbf))
      else $error("boot rom selected outside its window");
   chk_idle_sel : assert property (
      !cpuReq |-> sels == 6'h00)
      else $error("select without cpu request");
   chk_read_vis : assert property (
      readVisible |-> (cpuReq && !cpuWe && !selExternal &&
                       (opMode == MSMM_EXPANDED || opMode == MSMM_TEST)))
      else $error("read visibility in wrong mode or cycle");
   // mode state holds after capture
   chk_mode_hold : assert property (
      ($changed(opMode) && !$past(rst) && !$past(rst, 2)) |->
         ($past(wb_ack_o) && $past(wb_we_i)))
      else $error("mode changed without a register write");
   chk_vec_hold : assert property (
      (!$past(rst) && !$past(rst, 2)) |-> $stable(resetVector))
      else $error("reset vector changed after capture");
   // pin outputs
   chk_strobe : assert property (
      (!$past(rst) && !$past(rst, 2)) |->
         modePinAOe == $past(instrFirstCycle))
      else $error("load strobe not one cycle after instruction start");
   chk_eclk : assert property (
      eClkPin |-> $past(cpuEPhase))
      else $error("e pin high without e phase");
endmodule : msmm_top_asserts

bind msmm_top msmm_top_asserts u_chk (
   .clk, .rst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_ack_o, .instrFirstCycle,
   .cpuEPhase, .modePinAOe, .eClkPin, .cpuReq, .cpuWe, .cpuAddr, .regPage,
   .ramPage, .selRegs, .selRam, .selRom, .selBootRom, .selEeprom,
   .selExternal, .readVisible, .opMode, .resetVector
);

//--- sim/msmm_board.sv
`timescale 1ns/10ps
// ----------------------------------------------------------------------
// board straps and the shared open-drain pin a
// ----------------------------------------------------------------------
module msmm_board (
   // strap levels chosen by the bench
   input  wire logic strapA,
   input  wire logic strapB,
   // device side of pin a
   input  wire logic modePinAOut,
   input  wire logic modePinAOe,
   // levels seen by the device
   output      logic modePinAIn,
   output      logic modePinB
);
   // pin a: tie or pull-up, pulled low while the device strobes
   assign modePinAIn = modePinAOe ? modePinAOut : strapA;
   // pin b is a plain strap, read by the device only in reset
   assign modePinB = strapB;
endmodule : msmm_board

//--- sim/msmm_tb.sv
`timescale 1ns/10ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin \
   n_mismatch++; $display("BAD %s exp %h got %h", nm, e, g); end end
module tb;
   import msmm_pkg::*;
   // ----------------------------------------------------------------------
   // signals
   // ----------------------------------------------------------------------
   logic        clk, rst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
   logic        modePinAIn, modePinAOut, modePinAOe, modePinB, strapA, strapB;
   logic        instrFirstCycle, cpuEPhase, cpuReq, cpuWe, romEnableCfg;
   logic        selRegs, selRam, selRom, selBootRom, selEeprom, selExternal;
   logic        readVisible, eClkPin;
   logic [15:0] wb_adr_i, cpuAddr, resetVector;
   logic [3:0]  wb_sel_i, regPage, ramPage, eepromBaseSelect;
   logic [31:0] wb_dat_i, wb_dat_o;
   logic [5:0]  sels;
   logic [7:0]  rdData;
   msmm_mode_t  opMode;
   int          n_mismatch = 0;
   int          n_checks = 0;
   // per-mode straps and expected captured state
   logic [1:0]  pins [4] = '{2'h2, 2'h3, 2'h0, 2'h1};
   logic [7:0]  capV [4] = '{8'h06, 8'h26, 8'hc6, 8'h76};
   logic [15:0] vecV [4] = '{16'hfffa, 16'hfffa, 16'hbffa, 16'hbffa};
   msmm_mode_t  modeV [4] = '{MSMM_SINGLE, MSMM_EXPANDED, MSMM_BOOTSTRAP,
                              MSMM_TEST};

   msmm_top dut (
      .clk, .rst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
      .wb_dat_i, .wb_dat_o, .wb_ack_o, .modePinAIn, .modePinAOut,
      .modePinAOe, .modePinB, .instrFirstCycle, .cpuEPhase, .cpuReq, .cpuWe,
      .cpuAddr, .regPage, .ramPage, .romEnableCfg, .eepromBaseSelect,
      .selRegs, .selRam, .selRom, .selBootRom, .selEeprom, .selExternal,
      .readVisible, .eClkPin, .opMode, .resetVector
   );
   msmm_board board (
      .strapA, .strapB, .modePinAOut, .modePinAOe, .modePinAIn, .modePinB
   );
   assign sels = {selRegs, selRam, selRom, selBootRom, selEeprom,
                  selExternal};

   // ----------------------------------------------------------------------
   // clock, e phase and watchdog
   // ----------------------------------------------------------------------
   initial
   begin
      clk = 1'h0;
      forever #50 clk = ~clk;
   end
   always @(posedge clk) cpuEPhase <= ~cpuEPhase;
   initial
   begin
      repeat (5000) @(posedge clk);
      n_mismatch++;
      results();
   end

   // ----------------------------------------------------------------------
   // access tasks
   // ----------------------------------------------------------------------
   task automatic results;
      if (n_mismatch == 0 && n_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : results

   task automatic doReset(input logic [1:0] p);
      rst    <= 1'h1;
      strapB <= p[1];
      strapA <= p[0];
      repeat (6) @(posedge clk);
      rst <= 1'h0;
      repeat (3) @(posedge clk);
   endtask : doReset

   // one classic cycle; request held until the edge that samples ack high
   task automatic xfer(input logic w, input logic [15:0] a,
                       input logic [7:0] d);
      int i;
      wb_cyc_i <= 1'h1;
      wb_stb_i <= 1'h1;
      wb_we_i  <= w;
      wb_adr_i <= a;
      wb_dat_i <= {24'h000000, d};
      i = 0;
      @(posedge clk);
      while (wb_ack_o !== 1'h1 && i < 50)
      begin
         @(posedge clk);
         i++;
      end
      if (i >= 50)
      begin
         n_mismatch++;
         results();
      end
      // read data taken at the ack edge, then the request is released
      rdData = wb_dat_o[7:0];
      wb_cyc_i <= 1'h0;
      wb_stb_i <= 1'h0;
      wb_we_i  <= 1'h0;
      @(posedge clk);
   endtask : xfer

   task automatic rdChk(input logic [15:0] a, input logic [7:0] e);
      xfer(1'h0, a, 8'h00);
      `CHK("reg", e, rdData)
   endtask : rdChk

   task automatic dec(input logic [15:0] a, input logic [5:0] e);
      cpuReq  <= 1'h1;
      cpuAddr <= a;
      @(negedge clk);
      `CHK("sels", e, sels)
      @(posedge clk);
   endtask : dec

   // ----------------------------------------------------------------------
   // tests
   // ----------------------------------------------------------------------
   initial
   begin
      rst = 1'h1;
      {wb_cyc_i, wb_stb_i, wb_we_i, instrFirstCycle, cpuEPhase} = 5'h00;
      {cpuReq, cpuWe, romEnableCfg, strapA, strapB} = 5'h00;
      wb_adr_i = 16'h0000;
      wb_dat_i = 32'h00000000;
      wb_sel_i = 4'h1;
      cpuAddr = 16'h0000;
      regPage = 4'h1;
      ramPage = 4'h1;
      eepromBaseSelect = 4'h0;
      // capture, pin changes and mode-dependent map in each mode
      for (int i = 0; i < 4; i++)
      begin
         doReset(pins[i]);
         rdChk(16'h103c, capV[i]);
         `CHK("mode", modeV[i], opMode)
         `CHK("vector", vecV[i], resetVector)
         strapA <= ~pins[i][0];
         strapB <= ~pins[i][1];
         repeat (4) @(posedge clk);
         rdChk(16'h103c, capV[i]);
         romEnableCfg <= 1'h0;
         dec(16'hbf00, (i == 2) ? 6'h04 : 6'h01);
         dec(16'he000, (i % 2 == 0) ? 6'h08 : 6'h01);
         romEnableCfg <= 1'h1;
         dec(16'he000, 6'h08);
         dec(16'hb600, 6'h02);
      end
      // priority and read visibility in test mode
      dec(16'h1000, 6'h20);
      dec(16'h1040, 6'h10);
      `CHK("vis", 1'h1, readVisible)
      ramPage <= 4'he;
      dec(16'he000, 6'h10);
      dec(16'h4000, 6'h01);
      `CHK("vis", 1'h0, readVisible)
      cpuReq <= 1'h0;
      @(negedge clk);
      `CHK("sels", 6'h00, sels)
      // write protection of the flags from bootstrap
      doReset(2'h0);
      xfer(1'h1, 16'h103c, 8'h66);
      rdChk(16'h103c, 8'h66);
      `CHK("mode", MSMM_TEST, opMode)
      xfer(1'h1, 16'h103c, 8'h00);
      rdChk(16'h103c, 8'h00);
      dec(16'hbf00, 6'h01);
      xfer(1'h1, 16'h103c, 8'hff);
      rdChk(16'h103c, 8'h2f);
      xfer(1'h1, 16'h103c, 8'h00);
      rdChk(16'h103c, 8'h20);
      xfer(1'h1, 16'h1040, 8'hff);
      rdChk(16'h1040, 8'h00);
      rdChk(16'h103c, 8'h20);
      // e clock control and the load strobe in single chip
      doReset(2'h2);
      @(negedge clk);
      `CHK("eclk", ~cpuEPhase, eClkPin)
      xfer(1'h1, 16'h103c, 8'h1f);
      rdChk(16'h103c, 8'h1f);
      @(negedge clk);
      `CHK("eclk", 1'h0, eClkPin)
      xfer(1'h1, 16'h103c, 8'h0f);
      rdChk(16'h103c, 8'h1f);
      instrFirstCycle <= 1'h1;
      @(posedge clk);
      instrFirstCycle <= 1'h0;
      @(negedge clk);
      `CHK("strobe", 1'h1, modePinAOe)
      @(negedge clk);
      `CHK("strobe", 1'h0, modePinAOe)
      results();
   end
endmodule : tb
